// ### logic/stmr_timer.sv
// stamp timer: apb registers, slow counter, alarm and interrupt logic
// Operation
// - wrap select 0: wrap after 0xA8BF_FFFF
// - wrap select 1: wrap after 0xFFFF_FFFF
// - mask holds five per-source enable bits
// - mask reads back; one unmasks, zero masks
// - raw status shows sources; writes ignored
// - masked status is raw AND mask
// - clear register: one clears, zero keeps
// - status bit 6: count write pending
// - status bit 8: counter really running
// - status bit 9: alarm really armed
// - count register holds elapsed slow periods
// - wrap select 0 drops counts from 0xA8C0_0000
// - alarm source set after matching period
// - enable and disable together means disable
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ns
`include "stmr_params.svh"

module stmr_timer (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire stmr_pkg::stmr_addr_type paddr,
  input wire stmr_pkg::stmr_word_type pwdata,
  output stmr_pkg::stmr_word_type prdata,
  output logic pready,
  output logic pslverr,
  // slow counting clock, sampled as a pin
  input wire logic slow_clock,
  // interrupt request
  output logic irq
);
  import stmr_pkg::*;

  // slow clock synchroniser and edge detect
  logic slow_s1_reg, slow_s1_next;
  logic slow_s2_reg, slow_s2_next;
  logic slow_s3_reg, slow_s3_next;
  logic slow_tick;

  always_comb begin
    slow_s1_next = slow_clock;
    slow_s2_next = slow_s1_reg;
    slow_s3_next = slow_s2_reg;
    // only s2 and s3 feed the edge detector; s1 stays inside the synchroniser
    slow_tick = slow_s2_reg & ~slow_s3_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_s1_reg <= 1'b0;
      slow_s2_reg <= 1'b0;
      slow_s3_reg <= 1'b0;
    end else begin
      slow_s1_reg <= slow_s1_next;
      slow_s2_reg <= slow_s2_next;
      slow_s3_reg <= slow_s3_next;
    end
  end

  // apb handshake: one wait state, so read data and error come from flops
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  stmr_word_type prdata_reg, prdata_next;
  logic acc_first;
  logic acc_done;
  logic wr_en;
  logic mapped;

  // software-written configuration
  stmr_irq_type mask_reg, mask_next;
  logic wrap_reg, wrap_next;
  logic cnt_req_reg, cnt_req_next;
  logic alm_req_reg, alm_req_next;
  stmr_word_type alarm_reg, alarm_next;

  // slow domain state
  logic cnt_run_reg, cnt_run_next;
  logic alm_arm_reg, alm_arm_next;
  stmr_word_type count_reg, count_next;
  stmr_word_type pend_val_reg, pend_val_next;
  logic pend_reg, pend_next;

  // interrupt status and request
  stmr_irq_type raw_reg, raw_next;
  stmr_irq_type set_ev;
  stmr_irq_type clr_bits;
  logic irq_reg, irq_next;

  // write strobes, one per writable register
  logic wr_ctrl;
  logic wr_mode;
  logic wr_mask;
  logic wr_clr;
  logic wr_count;
  logic wr_alarm;

  stmr_word_type wrap_limit;
  stmr_word_type status_word;
  logic value_ok;
  logic at_limit;
  logic alarm_ev;

  always_comb begin
    acc_first = psel & penable & ~pready_reg;
    acc_done = psel & penable & pready_reg;
    wr_en = acc_done & pwrite;
    mapped = 1'b0;
    unique case (paddr)
      `STMR_OFF_CTRL, `STMR_OFF_MODE, `STMR_OFF_MASK, `STMR_OFF_RAW, `STMR_OFF_MSKD,
      `STMR_OFF_CLR, `STMR_OFF_STAT, `STMR_OFF_COUNT, `STMR_OFF_ALARM: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
    status_word = `STMR_ZERO32;
    status_word[`STMR_SR_PEND] = pend_reg;
    status_word[`STMR_SR_RUN] = cnt_run_reg;
    status_word[`STMR_SR_ARMED] = alm_arm_reg;
    pready_next = acc_first;
    pslverr_next = acc_first & ~mapped;
    prdata_next = prdata_reg;
    if (acc_first) begin
      prdata_next = `STMR_ZERO32;
      unique case (paddr)
        `STMR_OFF_MODE: begin
          prdata_next[`STMR_MODE_WRAP] = wrap_reg;
        end
        `STMR_OFF_MASK: begin
          prdata_next[`STMR_IRQ_W-1:0] = mask_reg;
        end
        `STMR_OFF_RAW: begin
          prdata_next[`STMR_IRQ_W-1:0] = raw_reg;
        end
        `STMR_OFF_MSKD: begin
          prdata_next[`STMR_IRQ_W-1:0] = raw_reg & mask_reg;
        end
        `STMR_OFF_STAT: begin
          prdata_next = status_word;
        end
        `STMR_OFF_COUNT: begin
          prdata_next = count_reg;
        end
        `STMR_OFF_ALARM: begin
          prdata_next = alarm_reg;
        end
        default: begin
          prdata_next = `STMR_ZERO32;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= `STMR_ZERO32;
    end else begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  // write strobes; writes to raw, masked and status fall to default and change nothing
  always_comb begin
    wr_ctrl = 1'b0;
    wr_mode = 1'b0;
    wr_mask = 1'b0;
    wr_clr = 1'b0;
    wr_count = 1'b0;
    wr_alarm = 1'b0;
    if (wr_en) begin
      unique case (paddr)
        `STMR_OFF_CTRL: begin
          wr_ctrl = 1'b1;
        end
        `STMR_OFF_MODE: begin
          wr_mode = 1'b1;
        end
        `STMR_OFF_MASK: begin
          wr_mask = 1'b1;
        end
        `STMR_OFF_CLR: begin
          wr_clr = 1'b1;
        end
        `STMR_OFF_COUNT: begin
          wr_count = 1'b1;
        end
        `STMR_OFF_ALARM: begin
          wr_alarm = 1'b1;
        end
        default: begin
          wr_ctrl = 1'b0;
        end
      endcase
    end
    // short wrap leaves values from the first invalid one upward unusable
    value_ok = wrap_reg | (pwdata < `STMR_FIRST_INVALID);
    clr_bits = wr_clr ? pwdata[`STMR_IRQ_W-1:0] : `STMR_IRQ_RESET;
  end

  // enable requests from the control register
  always_comb begin
    cnt_req_next = cnt_req_reg;
    alm_req_next = alm_req_reg;
    if (wr_ctrl) begin
      // disable is checked last so it wins over a simultaneous enable
      if (pwdata[`STMR_CTRL_CNT_ON]) begin
        cnt_req_next = 1'b1;
      end
      if (pwdata[`STMR_CTRL_CNT_OFF]) begin
        cnt_req_next = 1'b0;
      end
      if (pwdata[`STMR_CTRL_ALM_ON]) begin
        alm_req_next = 1'b1;
      end
      if (pwdata[`STMR_CTRL_ALM_OFF]) begin
        alm_req_next = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_req_reg <= 1'b0;
      alm_req_reg <= 1'b0;
    end else begin
      cnt_req_reg <= cnt_req_next;
      alm_req_reg <= alm_req_next;
    end
  end

  // mask, wrap select and alarm value
  always_comb begin
    mask_next = mask_reg;
    wrap_next = wrap_reg;
    alarm_next = alarm_reg;
    if (wr_mode) begin
      // no interlock: changing wrap while running is the caller's hazard
      wrap_next = pwdata[`STMR_MODE_WRAP];
    end
    if (wr_mask) begin
      mask_next = pwdata[`STMR_IRQ_W-1:0];
    end
    if (wr_alarm && value_ok) begin
      alarm_next = pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= `STMR_IRQ_RESET;
      wrap_reg <= 1'b0;
      alarm_reg <= `STMR_ZERO32;
    end else begin
      mask_reg <= mask_next;
      wrap_reg <= wrap_next;
      alarm_reg <= alarm_next;
    end
  end

  // real enable state follows the request only on a slow edge
  always_comb begin
    cnt_run_next = cnt_run_reg;
    alm_arm_next = alm_arm_reg;
    set_ev = `STMR_IRQ_RESET;
    set_ev[`STMR_IRQ_ALARM] = alarm_ev;
    if (slow_tick) begin
      cnt_run_next = cnt_req_reg;
      alm_arm_next = alm_req_reg;
      set_ev[`STMR_IRQ_CNT_ON] = cnt_req_reg & ~cnt_run_reg;
      set_ev[`STMR_IRQ_CNT_OFF] = ~cnt_req_reg & cnt_run_reg;
      set_ev[`STMR_IRQ_ALM_ON] = alm_req_reg & ~alm_arm_reg;
      set_ev[`STMR_IRQ_ALM_OFF] = ~alm_req_reg & alm_arm_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_run_reg <= 1'b0;
      alm_arm_reg <= 1'b0;
    end else begin
      cnt_run_reg <= cnt_run_next;
      alm_arm_reg <= alm_arm_next;
    end
  end

  // counter and parked count write, one step per slow clock rising edge
  always_comb begin
    count_next = count_reg;
    pend_val_next = pend_val_reg;
    pend_next = pend_reg;
    alarm_ev = 1'b0;
    wrap_limit = wrap_reg ? `STMR_WRAP_FULL : `STMR_WRAP_SHORT;
    at_limit = (count_reg == wrap_limit);
    if (slow_tick) begin
      if (pend_reg) begin
        count_next = pend_val_reg;
        pend_next = 1'b0;
      end else if (cnt_run_reg) begin
        alarm_ev = alm_arm_reg & (count_reg == alarm_reg);
        if (at_limit) begin
          count_next = `STMR_ZERO32;
        end else begin
          count_next = count_reg + `STMR_ONE32;
        end
      end
    end
    // a write meeting a slow edge is parked after that edge's update, so it is never lost
    if (wr_count && value_ok) begin
      pend_val_next = pwdata;
      pend_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= `STMR_ZERO32;
      pend_val_reg <= `STMR_ZERO32;
      pend_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      pend_val_reg <= pend_val_next;
      pend_reg <= pend_next;
    end
  end

  // one sticky flag per source; an event in the cycle of its clear keeps the flag set
  for (genvar i = 0; i < `STMR_IRQ_W; i++) begin : g_src
    logic flag_reg, flag_next;
    always_comb begin
      flag_next = flag_reg;
      if (clr_bits[i]) begin
        flag_next = 1'b0;
      end
      if (set_ev[i]) begin
        flag_next = 1'b1;
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        flag_reg <= 1'b0;
      end else begin
        flag_reg <= flag_next;
      end
    end
    assign raw_reg[i] = flag_reg;
    assign raw_next[i] = flag_next;
  end

  // irq is registered so the pin comes straight from a flop
  always_comb begin
    irq_next = |(raw_next & mask_next);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;
endmodule

// ### logic/stmr_params.svh
// offsets, field positions, reset values and limits of the stamp timer register block
`ifndef STMR_PARAMS_SVH
`define STMR_PARAMS_SVH

// register byte offsets
`define STMR_OFF_CTRL 12'h00C
`define STMR_OFF_MODE 12'h010
`define STMR_OFF_MASK 12'h014
`define STMR_OFF_RAW 12'h018
`define STMR_OFF_MSKD 12'h01C
`define STMR_OFF_CLR 12'h020
`define STMR_OFF_STAT 12'h024
`define STMR_OFF_COUNT 12'h028
`define STMR_OFF_ALARM 12'h02C

// control command bits
`define STMR_CTRL_CNT_ON 1
`define STMR_CTRL_CNT_OFF 2
`define STMR_CTRL_ALM_ON 3
`define STMR_CTRL_ALM_OFF 4

// interrupt source bits, shared by mask, raw, masked and clear registers
`define STMR_IRQ_ALARM 0
`define STMR_IRQ_CNT_ON 1
`define STMR_IRQ_CNT_OFF 2
`define STMR_IRQ_ALM_ON 3
`define STMR_IRQ_ALM_OFF 4
`define STMR_IRQ_W 5

// mode and status bits
`define STMR_MODE_WRAP 0
`define STMR_SR_PEND 6
`define STMR_SR_RUN 8
`define STMR_SR_ARMED 9

// counter limits
`define STMR_WRAP_SHORT 32'hA8BF_FFFF
`define STMR_WRAP_FULL 32'hFFFF_FFFF
`define STMR_FIRST_INVALID 32'hA8C0_0000

// reset values and the counter increment
`define STMR_ZERO32 32'h0000_0000
`define STMR_IRQ_RESET 5'h00
`define STMR_ONE32 32'h0000_0001

`endif

// ### logic/stmr_pkg.sv
// types shared by the stamp timer register block
package stmr_pkg;
  typedef logic [31:0] stmr_word_type;
  typedef logic [11:0] stmr_addr_type;
  typedef logic [4:0] stmr_irq_type;
endpackage

// ### verification/stmr_timer_assertions.sv
// port-level assertions for the stamp timer register block
`timescale 1ns/1ns
`include "stmr_params.svh"
module stmr_timer_assertions (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire stmr_pkg::stmr_addr_type paddr,
  input wire stmr_pkg::stmr_word_type pwdata,
  input wire stmr_pkg::stmr_word_type prdata,
  input wire logic pready,
  input wire logic pslverr,
  // slow clock and interrupt
  input wire logic slow_clock,
  input wire logic irq
);
  import stmr_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_done;
  assign rd_done = psel && penable && pready && !pwrite;
  a_one_wait_state: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not one cycle into access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside completion");
  a_unaligned_err: assert property (psel && penable && pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("unaligned access not refused");
  a_mask_rsvd_zero: assert property (rd_done && paddr == `STMR_OFF_MASK |-> prdata[31:5] == 27'h0)
    else $error("mask reserved bits set");
  a_raw_rsvd_zero: assert property (rd_done && paddr == `STMR_OFF_RAW |-> prdata[31:5] == 27'h0)
    else $error("raw reserved bits set");
  a_masked_rsvd_zero: assert property (rd_done && paddr == `STMR_OFF_MSKD |-> prdata[31:5] == 27'h0)
    else $error("masked reserved bits set");
  a_status_rsvd_zero: assert property (rd_done && paddr == `STMR_OFF_STAT |->
    prdata[31:10] == 22'h0 && prdata[7] == 1'h0 && prdata[5:0] == 6'h0)
    else $error("status reserved bits set");
endmodule

bind stmr_timer stmr_timer_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .slow_clock(slow_clock), .irq(irq));

// ### verification/stmr_timer_tb.sv
// self-checking bench for the stamp timer register block
`timescale 1ns/1ns
`include "stmr_params.svh"
module stmr_timer_tb;
  import stmr_pkg::*;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, slow_clock = 1'h0;
  logic pready, pslverr, irq;
  stmr_addr_type paddr = 12'h000;
  stmr_word_type pwdata = 32'h0, prdata, r, v, lim;
  int fail_count = 0, checked = 0, seed = 49;
  stmr_addr_type regs[6] = '{`STMR_OFF_MASK, `STMR_OFF_RAW, `STMR_OFF_MSKD, `STMR_OFF_STAT,
    `STMR_OFF_COUNT, `STMR_OFF_ALARM};
  always #25 pclk = ~pclk;
  stmr_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slow_clock(slow_clock), .irq(irq));
  task automatic chk(input string nm, input stmr_word_type seen, input stmr_word_type exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic unmapped(input stmr_addr_type a);
    return !(a inside {`STMR_OFF_CTRL, `STMR_OFF_MODE, `STMR_OFF_MASK, `STMR_OFF_RAW, `STMR_OFF_MSKD,
      `STMR_OFF_CLR, `STMR_OFF_STAT, `STMR_OFF_COUNT, `STMR_OFF_ALARM});
  endfunction
  // answer read right after the rising edge, i.e. the values that edge samples, before it updates them
  task automatic bus(input logic w, input stmr_addr_type a, input stmr_word_type d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk("pready", {31'h0, pready}, 32'h1);
    chk("pslverr", {31'h0, pslverr}, {31'h0, unmapped(a)});
    r = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic rc(input stmr_addr_type a, input stmr_word_type e);
    bus(1'h0, a, 32'h0);
    chk($sformatf("reg %h", a), r, e);
  endtask
  // slow phases of four bus cycles keep the pin well inside the sampling limit
  task automatic tick(input int k);
    repeat (k) begin
      repeat (4) @(posedge pclk);
      slow_clock <= 1'h1;
      repeat (4) @(posedge pclk);
      slow_clock <= 1'h0;
    end
    repeat (4) @(posedge pclk);
  endtask
  function automatic stmr_word_type nxt(input stmr_word_type c, input logic m);
    return (c == (m ? `STMR_WRAP_FULL : `STMR_WRAP_SHORT)) ? 32'h0 : c + 32'h1;
  endfunction
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #500000;
    fail_count++;
    tally_and_finish;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    foreach (regs[i]) rc(regs[i], 32'h0);
    rc(12'h030, 32'h0);
    rc(12'h015, 32'h0);
    repeat (4) begin
      v = $random(seed);
      bus(1'h1, `STMR_OFF_MASK, v);
      rc(`STMR_OFF_MASK, {27'h0, v[4:0]});
    end
    foreach (regs[i]) if (i > 0 && i < 4) bus(1'h1, regs[i], 32'hFFFF_FFFF);
    rc(`STMR_OFF_RAW, 32'h0);
    rc(`STMR_OFF_MSKD, 32'h0);
    v = $random(seed) & 32'h7FFF_FFFF;
    bus(1'h1, `STMR_OFF_COUNT, v);
    rc(`STMR_OFF_STAT, 32'h40);
    tick(1);
    rc(`STMR_OFF_STAT, 32'h0);
    rc(`STMR_OFF_COUNT, v);
    bus(1'h1, `STMR_OFF_COUNT, `STMR_FIRST_INVALID);
    tick(1);
    rc(`STMR_OFF_COUNT, v);
    bus(1'h1, `STMR_OFF_MASK, 32'h1F);
    bus(1'h1, `STMR_OFF_CTRL, 32'h2);
    tick(1);
    rc(`STMR_OFF_STAT, 32'h100);
    rc(`STMR_OFF_RAW, 32'h2);
    chk("irq", {31'h0, irq}, 32'h1);
    bus(1'h1, `STMR_OFF_CLR, 32'h1D);
    rc(`STMR_OFF_RAW, 32'h2);
    bus(1'h1, `STMR_OFF_CLR, 32'h2);
    rc(`STMR_OFF_RAW, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    bus(1'h1, `STMR_OFF_CTRL, 32'h6);
    tick(1);
    rc(`STMR_OFF_STAT, 32'h0);
    bus(1'h1, `STMR_OFF_CTRL, 32'h8);
    tick(1);
    rc(`STMR_OFF_STAT, 32'h200);
    rc(`STMR_OFF_MSKD, 32'hC);
    bus(1'h1, `STMR_OFF_MASK, 32'h0);
    rc(`STMR_OFF_MSKD, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    bus(1'h1, `STMR_OFF_CTRL, 32'h18);
    tick(1);
    rc(`STMR_OFF_STAT, 32'h0);
    for (int m = 0; m < 2; m++) begin
      lim = m ? `STMR_WRAP_FULL : `STMR_WRAP_SHORT;
      bus(1'h1, `STMR_OFF_MODE, 32'(m));
      bus(1'h1, `STMR_OFF_COUNT, lim - 32'h1);
      bus(1'h1, `STMR_OFF_ALARM, lim);
      bus(1'h1, `STMR_OFF_CLR, 32'h1F);
      tick(1);
      bus(1'h1, `STMR_OFF_CTRL, 32'hA);
      tick(1);
      v = lim - 32'h1;
      rc(`STMR_OFF_COUNT, v);
      repeat (2) begin
        tick(1);
        v = nxt(v, m[0]);
        rc(`STMR_OFF_COUNT, v);
      end
      rc(`STMR_OFF_RAW, 32'hB);
      bus(1'h1, `STMR_OFF_CTRL, 32'h14);
      tick(1);
    end
    tally_and_finish;
  end
endmodule
